/* File: logic/scs_pkg.sv */
package scs_pkg;
   // Register bus and map
   localparam int         AVS_DW       = 32;
   localparam int         AVS_AW       = 5;
   localparam logic [4:0] ADDR_CTRL    = 5'h00;
   localparam logic [4:0] ADDR_FREQ    = 5'h04;
   localparam logic [4:0] ADDR_STATUS  = 5'h08;
   localparam logic [4:0] ADDR_IRQ_ST  = 5'h0C;
   localparam logic [4:0] ADDR_IRQ_MSK = 5'h10;

   // Field positions
   localparam int CTRL_SRC_LSB = 0;
   localparam int CTRL_DIV_LSB = 4;
   localparam int ST_CUR_LSB   = 0;
   localparam int ST_OST_BIT   = 4;
   localparam int ST_DEAD_BIT  = 5;
   localparam int ST_BUSY_BIT  = 6;
   localparam int ST_MODE_LSB  = 8;
   localparam int ST_RSEL_LSB  = 12;
   localparam int IRQ_SWITCH   = 0;
   localparam int IRQ_FAIL     = 1;
   localparam int IRQ_OST      = 2;
   localparam int IRQ_W        = 3;
   localparam logic [2:0] IMASK_RST = 3'h0;

   // Source select codes, shared by reset and run-time select
   localparam logic [2:0] OSC_HF_64   = 3'h0;
   localparam logic [2:0] OSC_EXT_PLL = 3'h2;
   localparam logic [2:0] OSC_LF      = 3'h5;
   localparam logic [2:0] OSC_HF_1    = 3'h6;
   localparam logic [2:0] OSC_EXT     = 3'h7;

   // External mode codes
   localparam logic [2:0] MODE_LP  = 3'h0;
   localparam logic [2:0] MODE_XT  = 3'h1;
   localparam logic [2:0] MODE_HS  = 3'h2;
   localparam logic [2:0] MODE_ECL = 3'h4;
   localparam logic [2:0] MODE_ECM = 3'h5;
   localparam logic [2:0] MODE_ECH = 3'h6;
   localparam logic [1:0] GAIN_LOW  = 2'h0;
   localparam logic [1:0] GAIN_MED  = 2'h1;
   localparam logic [1:0] GAIN_HIGH = 2'h2;

   // Fast oscillator frequency codes, 1 MHz up to 64 MHz
   localparam logic [3:0] FRQ_1MHZ  = 4'h0;
   localparam logic [3:0] FRQ_64MHZ = 4'h8;
   localparam logic [3:0] FRQ_MAX   = 4'h8;

   // Dividers: log2 of ratio, 9 gives 1:512
   localparam logic [3:0] DIV_LOG_MAX = 4'h9;
   localparam logic [3:0] CLKOUT_LOG  = 4'h2;
   localparam int         DIV_CNT_W   = 8;

   // Timing
   localparam int OST_COUNT     = 1024;
   localparam int OST_W         = 11;
   localparam int CLK_PERIOD_NS = 8;
   localparam int FAIL_TIME_NS  = 100000;
   localparam int FAIL_CYCLES   = FAIL_TIME_NS / CLK_PERIOD_NS;
   localparam int FAIL_W        = 16;

   typedef enum logic [1:0] {
      SRC_HF  = 2'h0,
      SRC_LF  = 2'h1,
      SRC_EXT = 2'h2,
      SRC_PLL = 2'h3
   } scs_src_e;

   // Unknown codes fall back to the fast internal oscillator
   function automatic scs_src_e decode_source(input logic [2:0] code);
      if (code == OSC_EXT_PLL) return SRC_PLL;
      else if (code == OSC_EXT) return SRC_EXT;
      else if (code == OSC_LF) return SRC_LF;
      else return SRC_HF;
   endfunction

   function automatic logic uses_ext(input scs_src_e src);
      return (src == SRC_EXT) || (src == SRC_PLL);
   endfunction

   function automatic logic is_crystal(input logic [2:0] mode);
      return (mode == MODE_LP) || (mode == MODE_XT) || (mode == MODE_HS);
   endfunction

   // Low below 500 kHz, medium to 16 MHz or 4 MHz, high above
   function automatic logic [1:0] ext_gain(input logic [2:0] mode);
      if ((mode == MODE_LP) || (mode == MODE_ECL)) return GAIN_LOW;
      else if ((mode == MODE_XT) || (mode == MODE_ECM)) return GAIN_MED;
      else return GAIN_HIGH;
   endfunction
endpackage

/* File: logic/scs_sync.sv */
`timescale 1ns/1ps
module scs_sync #(
   parameter int W = 1
) (
   input  wire logic         mclk,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } scs_sync_s;

   scs_sync_s s_reg;
   scs_sync_s s_next;

   // Two stages; only the second stage leaves the module
   always_comb begin
      s_next      = s_reg;
      s_next.meta = d;
      s_next.sync = s_reg.meta;
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign q = s_reg.sync;
endmodule

/* File: logic/scs_div.sv */
`timescale 1ns/1ps
module scs_div #(
   parameter int CNT_W = 8,
   parameter int LOG_W = 4
) (
   input  wire logic             mclk,
   input  wire logic             sys_rst,
   input  wire logic             lvl,
   input  wire logic [LOG_W-1:0] log_sel,
   output logic                  q
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic             prev;
      logic             q;
   } scs_div_s;

   scs_div_s s_reg;
   scs_div_s s_next;

   // Toggle every 2**(log_sel-1) rising edges; zero passes the input
   always_comb begin
      logic [CNT_W-1:0] lim;
      lim    = '0;
      s_next = s_reg;
      s_next.prev = lvl;
      if (log_sel == '0) begin
         s_next.q   = lvl;
         s_next.cnt = '0;
      end else begin
         lim = CNT_W'((32'd1 << (log_sel - 1'b1)) - 32'd1);
         if (lvl && !s_reg.prev) begin
            // A ratio lowered mid-count wraps at once, no long pulse
            if (s_reg.cnt >= lim) begin
               s_next.q   = ~s_reg.q;
               s_next.cnt = '0;
            end else begin
               s_next.cnt = s_reg.cnt + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign q = s_reg.q;
endmodule

/* File: logic/scs_clock_select.sv */
`timescale 1ns/1ps
// What this block does
// RL1 - After every reset the start-up source comes from the reset select.
// RL2 - External sources run in the mode given by the external mode field.
// RL3 - Six external modes; clock modes by power: below 500k, to 16M, above.
// RL4 - Crystal modes: 32 kHz watch, medium gain to 4 MHz, high gain above.
// RL5 - Loss of the external clock forces the fast internal oscillator.
// RL6 - Fast internal frequency chosen by the frequency select register.
// RL7 - Slow internal oscillator is a fixed 31 kHz, selectable with code 101.
// RL8 - A times-four PLL path may clock the system from the external input.
// RL9 - Software run-time select picks external or internal system source.
// RL10 - Clock-out only when its enable is set and the pin is unused.
// RL11 - Clock-out runs at system clock divided by four.
// RL12 - Crystal modes wait 1024 oscillator edges after reset or wake.
// RL13 - Select code 010 chooses the external source through the PLL.
// RL14 - Divider select divides the fast internal clock from 1:1 to 1:512.
// RL15 - Source changes never glitch or cut short the system clock.
module scs_clock_select
   import scs_pkg::*;
#(
   parameter int FAIL_CYC = scs_pkg::FAIL_CYCLES
) (
   input  wire logic                       mclk,
   input  wire logic                       sys_rst,
   input  wire logic [scs_pkg::AVS_AW-1:0] avs_address,
   input  wire logic                       avs_read,
   input  wire logic                       avs_write,
   input  wire logic [scs_pkg::AVS_DW-1:0] avs_writedata,
   output logic      [scs_pkg::AVS_DW-1:0] avs_readdata,
   output logic                            avs_waitrequest,
   input  wire logic [2:0]                 cfg_reset_osc_select,
   input  wire logic [2:0]                 cfg_external_mode_select,
   input  wire logic                       cfg_clock_out_enable_n,
   input  wire logic                       wake_pulse,
   input  wire logic                       ext_osc_in,
   input  wire logic                       pll_clk_in,
   input  wire logic                       fast_osc_in,
   input  wire logic                       slow_osc_in,
   output logic                            sys_clk_out,
   output logic                            clkout_out,
   output logic                            clkout_oe,
   output logic                            irq,
   output logic      [3:0]                 fast_freq_out,
   output logic      [1:0]                 ext_gain_out,
   output logic                            ext_amp_en_out,
   output logic                            pll_enable_out
);
   typedef enum logic [3:0] {
      SW_LOAD = 4'b0001,
      SW_RUN  = 4'b0010,
      SW_OLD  = 4'b0100,
      SW_NEW  = 4'b1000
   } scs_sw_e;

   typedef struct packed {
      scs_sw_e           st;
      scs_src_e          cur;
      scs_src_e          tgt;
      logic [2:0]        rst_sel;
      logic [2:0]        ext_mode;
      logic              co_ok;
      logic [2:0]        src_code;
      logic [3:0]        div_sel;
      logic [3:0]        frq;
      logic [OST_W-1:0]  ost_cnt;
      logic              ost_done;
      logic [FAIL_W-1:0] idle_cnt;
      logic              ext_dead;
      logic              ext_prev;
      logic              sysclk;
      logic              co;
      logic              co_oe;
      logic              irq;
      logic [IRQ_W-1:0]  ist;
      logic [IRQ_W-1:0]  imask;
      logic              wreq;
      logic [AVS_DW-1:0] rdata;
      logic [1:0]        gain;
      logic              amp_en;
      logic              pll_en;
   } scs_state_s;

   scs_state_s s_reg;
   scs_state_s s_next;
   logic [3:0] pin_q;
   logic       hf_div;
   logic       co_div;

   // Every source pin is foreign to mclk
   scs_sync #(
      .W (4)
   ) u_sync (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .d       ({pll_clk_in, ext_osc_in, slow_osc_in, fast_osc_in}),
      .q       (pin_q)
   );

   // Post-divider on the fast internal oscillator
   scs_div #(
      .CNT_W (DIV_CNT_W),
      .LOG_W (4)
   ) u_hf_div (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .lvl     (pin_q[0]),
      .log_sel (s_reg.div_sel),
      .q       (hf_div)
   ); // RL14

   // Quarter-rate copy of the system clock for the pin
   scs_div #(
      .CNT_W (DIV_CNT_W),
      .LOG_W (4)
   ) u_co_div (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .lvl     (s_reg.sysclk),
      .log_sel (CLKOUT_LOG),
      .q       (co_div)
   ); // RL11

   function automatic logic src_level(input scs_src_e src,
                                      input logic [3:0] pins,
                                      input logic hf);
      case (src)
         SRC_LF:  return pins[1]; // RL7
         SRC_EXT: return pins[2];
         SRC_PLL: return pins[3]; // RL8
         default: return hf;
      endcase
   endfunction

   function automatic logic [3:0] clamp_div(input logic [3:0] v);
      return (v > DIV_LOG_MAX) ? DIV_LOG_MAX : v;
   endfunction

   // Whole block state: bus, start-up timer, monitor, switch sequencer
   always_comb begin
      logic [AVS_DW-1:0] rd;
      logic [IRQ_W-1:0]  ev;
      logic [IRQ_W-1:0]  clr;
      logic              wr_go;
      logic              e_ext;
      logic              cur_lv;
      logic              tgt_lv;
      logic              gate;
      logic              fail;
      scs_src_e          want;
      rd     = '0;
      ev     = '0;
      clr    = '0;
      s_next = s_reg;
      wr_go  = avs_write && !s_reg.wreq;
      e_ext  = pin_q[2] && !s_reg.ext_prev;
      cur_lv = src_level(s_reg.cur, pin_q, hf_div);
      tgt_lv = src_level(s_reg.tgt, pin_q, hf_div);
      gate   = !(uses_ext(s_reg.cur) && !s_reg.ost_done);
      fail   = uses_ext(s_reg.cur) && s_reg.ext_dead;
      want   = decode_source(s_reg.src_code); // RL13
      s_next.ext_prev = pin_q[2];

      // Register reads, answered one cycle after the request
      if (avs_address == ADDR_CTRL) begin
         rd[CTRL_SRC_LSB +: 3] = s_reg.src_code;
         rd[CTRL_DIV_LSB +: 4] = s_reg.div_sel;
      end else if (avs_address == ADDR_FREQ) begin
         rd[3:0] = s_reg.frq;
      end else if (avs_address == ADDR_STATUS) begin
         rd[ST_CUR_LSB +: 2]  = s_reg.cur;
         rd[ST_OST_BIT]       = s_reg.ost_done;
         rd[ST_DEAD_BIT]      = s_reg.ext_dead;
         rd[ST_BUSY_BIT]      = (s_reg.st != SW_RUN);
         rd[ST_MODE_LSB +: 3] = s_reg.ext_mode;
         rd[ST_RSEL_LSB +: 3] = s_reg.rst_sel;
      end else if (avs_address == ADDR_IRQ_ST) begin
         rd[IRQ_W-1:0] = s_reg.ist;
      end else if (avs_address == ADDR_IRQ_MSK) begin
         rd[IRQ_W-1:0] = s_reg.imask;
      end
      if (s_reg.wreq && (avs_read || avs_write)) begin
         s_next.wreq  = 1'b0;
         s_next.rdata = avs_read ? rd : '0;
      end else begin
         s_next.wreq  = 1'b1;
      end

      // Writes land at the edge where waitrequest is seen low
      if (wr_go) begin
         if (avs_address == ADDR_CTRL) begin
            s_next.src_code = avs_writedata[CTRL_SRC_LSB +: 3]; // RL9
            s_next.div_sel  = clamp_div(avs_writedata[CTRL_DIV_LSB +: 4]);
         end else if (avs_address == ADDR_FREQ) begin
            // Reserved codes are dropped, old frequency kept
            if (avs_writedata[3:0] <= FRQ_MAX) begin
               s_next.frq = avs_writedata[3:0]; // RL6
            end
         end else if (avs_address == ADDR_IRQ_ST) begin
            clr = avs_writedata[IRQ_W-1:0];
         end else if (avs_address == ADDR_IRQ_MSK) begin
            s_next.imask = avs_writedata[IRQ_W-1:0];
         end
      end

      // Fail-safe watchdog on external edges
      if (e_ext) begin
         s_next.idle_cnt = '0;
         s_next.ext_dead = 1'b0;
      end else if (s_reg.idle_cnt != FAIL_W'(FAIL_CYC - 1)) begin
         s_next.idle_cnt = s_reg.idle_cnt + 1'b1;
      end else begin
         s_next.ext_dead = 1'b1; // RL5
      end

      // Start-up timer; EC modes need none
      if (s_reg.st != SW_LOAD) begin
         if (!is_crystal(s_reg.ext_mode)) begin
            s_next.ost_done = 1'b1;
            s_next.ost_cnt  = '0;
         end else if (wake_pulse) begin
            s_next.ost_done = 1'b0; // RL12
            s_next.ost_cnt  = '0;
         end else if (!s_reg.ost_done && e_ext) begin
            if (s_reg.ost_cnt == OST_W'(OST_COUNT - 1)) begin
               s_next.ost_done = 1'b1; // RL12
               ev[IRQ_OST]     = 1'b1;
            end else begin
               s_next.ost_cnt = s_reg.ost_cnt + 1'b1;
            end
         end
      end

      // Switch sequencer: park low on old, leave on a low new source
      case (s_reg.st)
         SW_LOAD: begin
            s_next.rst_sel  = cfg_reset_osc_select; // RL1
            s_next.src_code = cfg_reset_osc_select; // RL1
            s_next.ext_mode = cfg_external_mode_select; // RL2
            s_next.co_ok    = !cfg_clock_out_enable_n &&
                              !is_crystal(cfg_external_mode_select); // RL10
            s_next.frq      = (cfg_reset_osc_select == OSC_HF_1) ?
                              FRQ_1MHZ : FRQ_64MHZ;
            s_next.ost_done = !is_crystal(cfg_external_mode_select);
            s_next.ost_cnt  = '0;
            s_next.st       = SW_RUN;
         end
         SW_RUN: begin
            s_next.sysclk = cur_lv && gate;
            if (fail) begin
               s_next.tgt     = SRC_HF; // RL5
               s_next.sysclk  = 1'b0;
               s_next.st      = SW_NEW;
               ev[IRQ_FAIL]   = 1'b1;
            end else if ((want != s_reg.cur) &&
                         !(uses_ext(want) && s_reg.ext_dead)) begin
               s_next.tgt = want; // RL9
               s_next.st  = SW_OLD;
            end
         end
         SW_OLD: begin
            s_next.sysclk = cur_lv && gate;
            if (fail) begin
               // A dead clock held high is no runt when dropped
               s_next.tgt     = SRC_HF; // RL5
               s_next.sysclk  = 1'b0;
               s_next.st      = SW_NEW;
               ev[IRQ_FAIL]   = 1'b1;
            end else if (!(cur_lv && gate)) begin
               s_next.st = SW_NEW; // RL15
            end
         end
         SW_NEW: begin
            s_next.sysclk = 1'b0;
            if (uses_ext(s_reg.tgt) && s_reg.ext_dead) begin
               s_next.tgt   = SRC_HF; // RL5
               ev[IRQ_FAIL] = 1'b1;
            end else if (!tgt_lv &&
                         (!uses_ext(s_reg.tgt) || s_reg.ost_done)) begin
               s_next.cur     = s_reg.tgt; // RL15
               s_next.st      = SW_RUN;
               ev[IRQ_SWITCH] = 1'b1;
            end
         end
         default: begin
            s_next.st = SW_LOAD;
         end
      endcase

      // Pin and analog controls, set over clear on the sticky bits
      s_next.co     = s_reg.co_ok && co_div; // RL11
      s_next.co_oe  = s_reg.co_ok; // RL10
      s_next.gain   = ext_gain(s_next.ext_mode); // RL3
      s_next.amp_en = is_crystal(s_next.ext_mode) &&
                      (s_next.st != SW_LOAD); // RL4
      s_next.pll_en = (s_next.cur == SRC_PLL) ||
                      (s_next.tgt == SRC_PLL); // RL8
      s_next.ist    = (s_reg.ist & ~clr) | ev;
      s_next.irq    = |(s_next.ist & s_next.imask);
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         s_reg          <= '0;
         s_reg.st       <= SW_LOAD;
         s_reg.cur      <= SRC_HF;
         s_reg.tgt      <= SRC_HF;
         s_reg.ext_mode <= MODE_ECH;
         s_reg.frq      <= FRQ_64MHZ;
         s_reg.imask    <= IMASK_RST;
         s_reg.wreq     <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // All outputs straight from state flops
   assign avs_readdata    = s_reg.rdata;
   assign avs_waitrequest = s_reg.wreq;
   assign sys_clk_out     = s_reg.sysclk;
   assign clkout_out      = s_reg.co;
   assign clkout_oe       = s_reg.co_oe;
   assign irq             = s_reg.irq;
   assign fast_freq_out   = s_reg.frq;
   assign ext_gain_out    = s_reg.gain;
   assign ext_amp_en_out  = s_reg.amp_en;
   assign pll_enable_out  = s_reg.pll_en;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   AST_CFG_LOAD: assert property ( // RL1
      $changed(s_reg.st) && ($past(s_reg.st) == SW_LOAD) |->
         (s_reg.src_code == $past(cfg_reset_osc_select)) &&
         (s_reg.ext_mode == $past(cfg_external_mode_select)))
      else $error("reset select not captured");

   AST_SWITCH_LOW: assert property ( // RL15
      (s_reg.cur != $past(s_reg.cur)) |-> !$past(s_reg.sysclk) && !sys_clk_out)
      else $error("source changed while clock high");

   AST_FAIL_TAKEOVER: assert property ( // RL5
      (s_reg.st == SW_RUN) && uses_ext(s_reg.cur) && s_reg.ext_dead |=>
         (s_reg.st == SW_NEW) && (s_reg.tgt == SRC_HF) && s_reg.ist[IRQ_FAIL])
      else $error("fail-safe did not take over");

   AST_OST_GATE: assert property ( // RL12
      uses_ext(s_reg.cur) && is_crystal(s_reg.ext_mode) && !s_reg.ost_done
         |=> !sys_clk_out)
      else $error("crystal used before start-up count");

   AST_CLKOUT_OFF: assert property ( // RL10
      !s_reg.co_ok |=> !clkout_oe && !clkout_out)
      else $error("clock-out driven while not allowed");

   AST_FREQ_WRITE: assert property ( // RL6
      avs_write && !avs_waitrequest && (avs_address == ADDR_FREQ) &&
      (avs_writedata[3:0] <= FRQ_MAX) |=>
         fast_freq_out == $past(avs_writedata[3:0]))
      else $error("frequency select not stored");

   AST_PLL_ON: assert property ( // RL8
      (s_reg.cur == SRC_PLL) |-> pll_enable_out && $past(pll_enable_out))
      else $error("PLL path off while selected");

   AST_SW_START: assert property ( // RL9
      (s_reg.st == SW_RUN) && !uses_ext(s_reg.cur) &&
      (decode_source(s_reg.src_code) == SRC_LF) && (s_reg.cur != SRC_LF)
         |=> (s_reg.st == SW_OLD) && (s_reg.tgt == SRC_LF))
      else $error("run-time select ignored");

   AST_ACK_ONE: assert property (
      !avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low longer than one cycle");

   AST_IRQ_LEVEL: assert property (
      irq == |(s_reg.ist & s_reg.imask))
      else $error("interrupt out of step with status");
endmodule

/* File: testbench/scs_src_model.sv */
`timescale 1ns/1ps
// Far-side sources: crystal or logic clock, PLL output, internal oscillators
module scs_src_model (
   input  wire logic ext_run,
   output logic      ext_osc,
   output logic      pll_clk,
   output logic      fast_osc,
   output logic      slow_osc
);
   // Odd half periods keep every source out of phase with mclk
   initial begin
      ext_osc = 1'b0;
      forever #43 ext_osc = ext_run ? !ext_osc : 1'b0;
   end
   // PLL half period is 31 ns against 43 ns for the external clock, scaled to stay slow here
   initial begin
      pll_clk = 1'b0;
      forever #31 pll_clk = ext_run ? !pll_clk : 1'b0;
   end
   // Internal oscillators run free
   initial begin
      fast_osc = 1'b0;
      forever #27 fast_osc = !fast_osc;
   end
   initial begin
      slow_osc = 1'b0;
      forever #61 slow_osc = !slow_osc;
   end
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import scs_pkg::*;
   logic        mclk, sys_rst, avs_read, avs_write, wake_pulse, ext_run;
   logic [4:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic        avs_waitrequest, sys_clk_out, clkout_out, clkout_oe, irq;
   logic        ext_osc, pll_clk, fast_osc, slow_osc, co_n, amp_en, pll_en;
   logic [2:0]  rsel, mode;
   logic [3:0]  freq;
   logic [1:0]  gain;
   int          num_errors, comparisons, hi_n, n;

   scs_src_model src_u (.ext_run(ext_run), .ext_osc(ext_osc),
      .pll_clk(pll_clk), .fast_osc(fast_osc), .slow_osc(slow_osc));
   scs_clock_select #(.FAIL_CYC(64)) dut_u (.mclk(mclk), .sys_rst(sys_rst),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .cfg_reset_osc_select(rsel), .cfg_external_mode_select(mode),
      .cfg_clock_out_enable_n(co_n), .wake_pulse(wake_pulse),
      .ext_osc_in(ext_osc), .pll_clk_in(pll_clk), .fast_osc_in(fast_osc),
      .slow_osc_in(slow_osc), .sys_clk_out(sys_clk_out),
      .clkout_out(clkout_out), .clkout_oe(clkout_oe), .irq(irq),
      .fast_freq_out(freq), .ext_gain_out(gain), .ext_amp_en_out(amp_en),
      .pll_enable_out(pll_en));

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   task automatic tally_and_finish;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic fail(input string nm, input logic [31:0] e, g);
      num_errors++;
      $display("unexpected %s expected %0h seen %0h", nm, e, g);
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      comparisons++;
      if (g !== e) fail(nm, e, g);
   endtask
   // One Avalon transfer; request held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [4:0] a,
                      input logic [31:0] d);
      int k;
      k = 0;
      @(posedge mclk);
      avs_write <= wr;
      avs_read <= !wr;
      avs_address <= a;
      avs_writedata <= d;
      do begin
         @(posedge mclk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 50);
      if (k >= 50) fail("waitrequest", 0, 1);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wait_irq(input int lim);
      n = 0;
      while (irq !== 1'b1 && n < lim) begin
         @(posedge mclk);
         n++;
      end
      chk("irq", 1, irq);
   endtask
   task automatic do_reset;
      sys_rst <= 1'b1;
      repeat (16) @(posedge mclk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask

   task automatic t_reset;
      // Start-up switch to the reset source takes a few source phases
      repeat (40) @(posedge mclk);
      bus(1'b0, ADDR_CTRL, 0);
      chk("ctrl", OSC_EXT, q);
      bus(1'b0, ADDR_STATUS, 0);
      chk("cur", SRC_EXT, q[1:0]);
      chk("mode", MODE_ECM, q[10:8]);
      chk("ec start", 1, q[ST_OST_BIT]);
      chk("gain", GAIN_MED, gain);
      chk("oe", 1, clkout_oe);
      bus(1'b0, ADDR_FREQ, 0);
      chk("freq", FRQ_64MHZ, q);
   endtask
   // Count rises of both clocks over a window
   task automatic t_clkout;
      int s, c;
      logic ps, pc;
      s = 0;
      c = 0;
      ps = sys_clk_out;
      pc = clkout_out;
      repeat (1600) begin
         @(posedge mclk);
         if (sys_clk_out && !ps) s++;
         if (clkout_out && !pc) c++;
         ps = sys_clk_out;
         pc = clkout_out;
      end
      chk("sysclk rises", 1, s > 100);
      comparisons++;
      if (c * 4 > s + 4 || c * 4 + 4 < s) fail("clkout rises", s / 4, c);
   endtask
   task automatic t_switch;
      // Start-up switch left its done bit set
      bus(1'b1, ADDR_IRQ_ST, 32'h7);
      bus(1'b1, ADDR_IRQ_MSK, 32'h7);
      bus(1'b1, ADDR_CTRL, OSC_LF);
      wait_irq(2000);
      bus(1'b0, ADDR_STATUS, 0);
      chk("cur", SRC_LF, q[1:0]);
      bus(1'b1, ADDR_IRQ_ST, 32'h7);
      repeat (2) @(posedge mclk);
      chk("irq clear", 0, irq);
      bus(1'b1, ADDR_CTRL, OSC_EXT_PLL);
      wait_irq(2000);
      bus(1'b0, ADDR_STATUS, 0);
      chk("cur", SRC_PLL, q[1:0]);
      chk("pll en", 1, pll_en);
      bus(1'b1, ADDR_IRQ_ST, 32'h7);
      bus(1'b1, ADDR_FREQ, 32'h3);
      bus(1'b1, ADDR_FREQ, 32'h9);
      bus(1'b0, ADDR_FREQ, 0);
      chk("freq", 32'h3, q);
      chk("freq pin", 4'h3, freq);
      bus(1'b1, ADDR_CTRL, 32'hC2);
      bus(1'b0, ADDR_CTRL, 0);
      chk("div clamp", 32'h92, q);
      bus(1'b1, ADDR_CTRL, OSC_EXT_PLL);
      bus(1'b0, 5'h14, 0);
      chk("unmapped", 0, q);
   endtask
   task automatic t_failsafe;
      ext_run <= 1'b0;
      wait_irq(2000);
      repeat (100) @(posedge mclk);
      bus(1'b0, ADDR_STATUS, 0);
      chk("dead", 1, q[ST_DEAD_BIT]);
      chk("cur", SRC_HF, q[1:0]);
      bus(1'b1, ADDR_CTRL, OSC_HF_64);
      ext_run <= 1'b1;
      bus(1'b1, ADDR_IRQ_ST, 32'h7);
   endtask
   // Crystal mode: pin is taken, start-up waits 1024 source edges
   task automatic t_crystal;
      logic ps;
      mode <= MODE_XT;
      do_reset();
      chk("oe", 0, clkout_oe);
      chk("gain", GAIN_MED, gain);
      bus(1'b1, ADDR_IRQ_MSK, 32'h4);
      wait_irq(30000);
      chk("amp", 1, amp_en);
      comparisons++;
      if (n < 10800) fail("start cycles", 10800, n);
      bus(1'b1, ADDR_IRQ_ST, 32'h4);
      // Wake just after a fall, so the restart cuts no high phase
      ps = 1'b0;
      while (!(ps && sys_clk_out === 1'b0)) begin
         ps = sys_clk_out;
         @(posedge mclk);
      end
      wake_pulse <= 1'b1;
      @(posedge mclk);
      wake_pulse <= 1'b0;
      wait_irq(30000);
      comparisons++;
      if (n < 10800) fail("wake cycles", 10800, n);
   endtask

   // A one-cycle high phase would be a runt on the system clock
   always @(posedge mclk) begin
      if (sys_clk_out === 1'b1) hi_n++;
      else begin
         if (hi_n == 1 && !sys_rst) fail("runt", 2, 1);
         hi_n = 0;
      end
   end

   initial begin
      {sys_rst, avs_read, avs_write, wake_pulse, co_n} = 5'h10;
      avs_address = 5'h00;
      avs_writedata = 32'h0;
      rsel = OSC_EXT;
      mode = MODE_ECM;
      ext_run = 1'b1;
      num_errors = 0;
      comparisons = 0;
      hi_n = 0;
      do_reset();
      t_reset();
      t_clkout();
      t_switch();
      t_failsafe();
      t_crystal();
      tally_and_finish();
   end
   // Watchdog at 50000 cycles, well past the expected run of about 24000 cycles
   initial begin
      #400000;
      fail("timeout", 0, 1);
      tally_and_finish();
   end
endmodule
